// ### hdl/cmc_mode_control.sv
// processor mode configuration register, cache status controls and fpu hooks
`default_nettype none

// Functional notes
// - with lock set, later writes to the mode control register are ignored
// - slow bus bit lengthens the wait before the bus changes direction
// - burst fill bit set fetches four words on a data miss, else one
// - one-hot fpu interrupt field picks which interrupt input carries fpu exceptions
// - halt bit stalls the processor until reset or an interrupt arrives
// - reduced clock bit divides processor and system clock rate by sixteen
// - alternate cache bit splits caches into eight kilobytes each
// - reserved bits are written as zero by software and read back as zero
// - cache isolate keeps stores and miss fills away from external memory
// - cache swap sends data accesses to the instruction cache
// - status miss flag reports whether the last data cache access missed
// - with coprocessor 1 unusable, each fpu instruction raises a trap
// - fpu condition comes from compares or control moves, never the pin
// - fpu interrupt defaults to input 3; its external pin is ignored
// - burst fill bit starts from the reset strap, software may change it
module cmc_mode_control
  import cmc_pkg::*;
#(
  parameter int INT_W = CMC_INT_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [4:0] cp0_reg_sel,
  input wire logic cp0_wr_en,
  input wire logic [31:0] cp0_wdata,
  output logic [31:0] cp0_rdata,
  input wire logic mode_burst_fill_strap,
  input wire logic [INT_W-1:0] int_pins_n,
  input wire logic fpu_exception,
  output logic [INT_W-1:0] cpu_int,
  output logic cpu_stall,
  output logic cpu_clk_tick,
  output logic sysclk_tick,
  input wire logic bus_turn_req,
  output logic bus_turn_ready,
  input wire logic store_req,
  output logic mem_store_en,
  input wire logic dcache_access,
  input wire logic dcache_hit,
  output logic fill_word_req,
  output logic [1:0] fill_word_index,
  input wire logic mem_word_ack,
  output logic dside_to_icache,
  output logic [4:0] icache_kb,
  output logic [4:0] dcache_kb,
  input wire logic fp_instr_valid,
  output logic cop1_trap,
  input wire logic fpu_cmp_valid,
  input wire logic fpu_cmp_result,
  input wire logic fpu_cond_wr,
  input wire logic fpu_cond_wdata,
  output logic fpu_condition_flag
);

  cmc_mode_t mode;
  cmc_mode_t next_mode;
  cmc_status_t status;
  cmc_status_t next_status;
  logic [3:0] clk_div;
  logic [3:0] turn_count;
  logic [2:0] fill_left;
  logic [2:0] next_fill_left;
  logic [1:0] next_fill_index;
  logic wake_event;
  logic [INT_W-1:0] next_cpu_int;
  logic [31:0] mode_word;
  logic [31:0] status_word;
  logic [31:0] next_rdata;

  wire mode_wr = cp0_wr_en && (cp0_reg_sel == CMC_SEL_MODE_CONTROL);
  wire status_wr = cp0_wr_en && (cp0_reg_sel == CMC_SEL_STATUS);
  wire mode_wr_ok = mode_wr && !mode.lock;
  wire status_rd = (cp0_reg_sel == CMC_SEL_STATUS);
  wire mode_rd = (cp0_reg_sel == CMC_SEL_MODE_CONTROL);
  wire div_last = (clk_div == CMC_CLK_DIV_LAST);
  wire tick_now = !mode.reduced_clock || div_last;
  wire fill_start = dcache_access && !dcache_hit && !status.cache_isolate_bit &&
                    (fill_left == 3'h0);
  wire [2:0] fill_words = mode.data_miss_burst_fill ? CMC_WORDS_BURST
                                                    : CMC_WORDS_SINGLE;
  wire fpu_sel_onehot = (mode.fpu_irq_select != '0) &&
                        ((mode.fpu_irq_select & (mode.fpu_irq_select - 1'b1)) == '0);
  wire [3:0] turn_load = mode.slow_bus ? CMC_TURN_SLOW_CYC : CMC_TURN_NORMAL_CYC;

  // interrupt routing: the input owned by the fpu drops its pin and carries the
  // fpu exception instead; a malformed selection leaves all pins untouched
  genvar gi;
  generate
    for (gi = 0; gi < INT_W; gi++) begin : g_int
      wire owned = fpu_sel_onehot && mode.fpu_irq_select[gi];
      assign next_cpu_int[gi] = owned ? fpu_exception : !int_pins_n[gi];
    end
  endgenerate

  assign wake_event = (next_cpu_int != '0);

  always_comb begin
    next_mode = mode;
    if (mode_wr_ok) begin
      next_mode.lock = cp0_wdata[CMC_LOCK_BIT];
      next_mode.slow_bus = cp0_wdata[CMC_SLOW_BUS_BIT];
      next_mode.data_miss_burst_fill = cp0_wdata[CMC_BURST_FILL_BIT];
      next_mode.fpu_irq_select = cp0_wdata[CMC_FPU_IRQ_LSB +: INT_W];
      next_mode.halt = cp0_wdata[CMC_HALT_BIT];
      next_mode.reduced_clock = cp0_wdata[CMC_REDUCED_CLOCK_BIT];
      next_mode.alternate_cache_split = cp0_wdata[CMC_ALT_CACHE_BIT];
    end
    // wake beats a halt write in the same cycle so an arriving interrupt is not lost
    if (wake_event) begin
      next_mode.halt = 1'b0;
    end
  end

  always_comb begin
    next_status = status;
    if (status_wr) begin
      next_status.cu1 = cp0_wdata[CMC_CU1_BIT];
      next_status.cache_swap = cp0_wdata[CMC_SWAP_BIT];
      next_status.cache_isolate_bit = cp0_wdata[CMC_ISOLATE_BIT];
    end
    // miss flag is hardware owned; software writes never touch it
    if (dcache_access) begin
      next_status.cache_miss_flag = !dcache_hit;
    end
  end

  always_comb begin
    mode_word = CMC_ZERO_WORD;
    mode_word[CMC_LOCK_BIT] = mode.lock;
    mode_word[CMC_SLOW_BUS_BIT] = mode.slow_bus;
    mode_word[CMC_BURST_FILL_BIT] = mode.data_miss_burst_fill;
    mode_word[CMC_FPU_IRQ_LSB +: INT_W] = mode.fpu_irq_select;
    mode_word[CMC_HALT_BIT] = mode.halt;
    mode_word[CMC_REDUCED_CLOCK_BIT] = mode.reduced_clock;
    mode_word[CMC_ALT_CACHE_BIT] = mode.alternate_cache_split;
  end

  always_comb begin
    status_word = CMC_ZERO_WORD;
    status_word[CMC_CU1_BIT] = status.cu1;
    status_word[CMC_MISS_BIT] = status.cache_miss_flag;
    status_word[CMC_SWAP_BIT] = status.cache_swap;
    status_word[CMC_ISOLATE_BIT] = status.cache_isolate_bit;
  end

  always_comb begin
    if (mode_rd) begin
      next_rdata = mode_word;
    end else if (status_rd) begin
      next_rdata = status_word;
    end else begin
      next_rdata = CMC_ZERO_WORD;
    end
  end

  always_comb begin
    next_fill_left = fill_left;
    next_fill_index = fill_word_index;
    if (fill_start) begin
      next_fill_left = fill_words;
      next_fill_index = 2'h0;
    end else if ((fill_left != 3'h0) && mem_word_ack) begin
      next_fill_left = fill_left - 3'h1;
      next_fill_index = fill_word_index + 2'h1;
    end
  end

  // sync reset loads the strap directly; only the fill size follows it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode <= '{lock: 1'b0, slow_bus: 1'b0, data_miss_burst_fill: mode_burst_fill_strap,
                fpu_irq_select: CMC_FPU_IRQ_RESET, halt: 1'b0, reduced_clock: 1'b0,
                alternate_cache_split: 1'b0};
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cp0_rdata <= CMC_ZERO_WORD;
      cpu_int <= '0;
    end else begin
      cp0_rdata <= next_rdata;
      cpu_int <= next_cpu_int;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !mode.reduced_clock) begin
      clk_div <= 4'h0;
    end else begin
      clk_div <= clk_div + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cpu_clk_tick <= 1'b0;
      sysclk_tick <= 1'b0;
    end else begin
      cpu_clk_tick <= tick_now && !next_mode.halt;
      sysclk_tick <= tick_now;
    end
  end

  assign cpu_stall = mode.halt;

  // a new request restarts the count, so back to back turns each get the full gap
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      turn_count <= 4'h0;
    end else if (bus_turn_req) begin
      turn_count <= turn_load;
    end else if (turn_count != 4'h0) begin
      turn_count <= turn_count - 4'h1;
    end
  end

  assign bus_turn_ready = (turn_count == 4'h0) && !bus_turn_req;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fill_left <= 3'h0;
      fill_word_index <= 2'h0;
    end else begin
      fill_left <= next_fill_left;
      fill_word_index <= next_fill_index;
    end
  end

  assign fill_word_req = (fill_left != 3'h0);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_store_en <= 1'b0;
      cop1_trap <= 1'b0;
      fpu_condition_flag <= 1'b0;
    end else begin
      mem_store_en <= store_req && !status.cache_isolate_bit;
      cop1_trap <= fp_instr_valid && !status.cu1;
      if (fpu_cmp_valid) begin
        fpu_condition_flag <= fpu_cmp_result;
      end else if (fpu_cond_wr) begin
        fpu_condition_flag <= fpu_cond_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dside_to_icache <= 1'b0;
      icache_kb <= CMC_ICACHE_KB_NORMAL;
      dcache_kb <= CMC_DCACHE_KB_NORMAL;
    end else begin
      dside_to_icache <= status.cache_swap;
      icache_kb <= mode.alternate_cache_split ? CMC_CACHE_KB_ALT : CMC_ICACHE_KB_NORMAL;
      dcache_kb <= mode.alternate_cache_split ? CMC_CACHE_KB_ALT : CMC_DCACHE_KB_NORMAL;
    end
  end

endmodule
`default_nettype wire

// ### include/cmc_pkg.sv
// shared constants and types for the processor mode configuration block
`default_nettype none
package cmc_pkg;
  localparam int CMC_INT_W = 6;
  localparam logic [4:0] CMC_SEL_MODE_CONTROL = 5'h03;
  localparam logic [4:0] CMC_SEL_STATUS = 5'h0c;
  localparam int CMC_LOCK_BIT = 31;
  localparam int CMC_SLOW_BUS_BIT = 30;
  localparam int CMC_BURST_FILL_BIT = 29;
  localparam int CMC_FPU_IRQ_LSB = 23;
  localparam int CMC_HALT_BIT = 22;
  localparam int CMC_REDUCED_CLOCK_BIT = 21;
  localparam int CMC_ALT_CACHE_BIT = 20;
  localparam int CMC_ISOLATE_BIT = 16;
  localparam int CMC_SWAP_BIT = 17;
  localparam int CMC_MISS_BIT = 19;
  localparam int CMC_CU1_BIT = 29;
  localparam logic [CMC_INT_W-1:0] CMC_FPU_IRQ_RESET = 6'h08;
  localparam logic [31:0] CMC_ZERO_WORD = 32'h0000_0000;
  localparam logic [2:0] CMC_WORDS_BURST = 3'h4;
  localparam logic [2:0] CMC_WORDS_SINGLE = 3'h1;
  localparam logic [3:0] CMC_CLK_DIV_LAST = 4'hf;
  localparam logic [4:0] CMC_ICACHE_KB_NORMAL = 5'h10;
  localparam logic [4:0] CMC_DCACHE_KB_NORMAL = 5'h04;
  localparam logic [4:0] CMC_CACHE_KB_ALT = 5'h08;
  localparam int CMC_CLK_PERIOD_NS = 10;
  localparam int CMC_TURN_NORMAL_NS = 15;
  localparam int CMC_TURN_SLOW_NS = 45;
  localparam int CMC_TURN_NORMAL_RAW = (CMC_TURN_NORMAL_NS + CMC_CLK_PERIOD_NS - 1)
                                       / CMC_CLK_PERIOD_NS;
  localparam int CMC_TURN_SLOW_RAW = (CMC_TURN_SLOW_NS + CMC_CLK_PERIOD_NS - 1)
                                     / CMC_CLK_PERIOD_NS;
  localparam logic [3:0] CMC_TURN_NORMAL_CYC = 4'(CMC_TURN_NORMAL_RAW);
  localparam logic [3:0] CMC_TURN_SLOW_CYC = 4'(CMC_TURN_SLOW_RAW);

  typedef struct packed {
    logic lock;
    logic slow_bus;
    logic data_miss_burst_fill;
    logic [CMC_INT_W-1:0] fpu_irq_select;
    logic halt;
    logic reduced_clock;
    logic alternate_cache_split;
  } cmc_mode_t;

  typedef struct packed {
    logic cu1;
    logic cache_miss_flag;
    logic cache_swap;
    logic cache_isolate_bit;
  } cmc_status_t;
endpackage
`default_nettype wire

// ### tb/cmc_mode_control_assertions.sv
// property checks on the mode control block ports
`default_nettype none
module cmc_mode_control_assertions
  import cmc_pkg::*;
#(
  parameter int INT_W = CMC_INT_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [4:0] cp0_reg_sel,
  input wire logic [31:0] cp0_rdata,
  input wire logic [INT_W-1:0] cpu_int,
  input wire logic cpu_stall,
  input wire logic bus_turn_req,
  input wire logic bus_turn_ready,
  input wire logic store_req,
  input wire logic mem_store_en,
  input wire logic fill_word_req,
  input wire logic [1:0] fill_word_index,
  input wire logic mem_word_ack,
  input wire logic dside_to_icache,
  input wire logic [4:0] icache_kb,
  input wire logic [4:0] dcache_kb,
  input wire logic fp_instr_valid,
  input wire logic cop1_trap
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_RSVD_ZERO: assert property (
    $past(cp0_reg_sel) == CMC_SEL_MODE_CONTROL |-> cp0_rdata[19:0] == 20'h0_0000
  ) else $error("reserved bits nonzero");
  // halt self-clears on wake, so that bit is masked; a reset legally clears the word
  AST_LOCK: assert property (
    !reset && cp0_reg_sel == CMC_SEL_MODE_CONTROL && $stable(cp0_reg_sel) && cp0_rdata[31]
    |=> (cp0_rdata | 32'h0040_0000) == ($past(cp0_rdata) | 32'h0040_0000)
  ) else $error("locked register changed");
  AST_WAKE: assert property (
    cpu_int != '0 |-> !cpu_stall) else $error("halted with interrupt");
  AST_TURN_HOLD: assert property (
    bus_turn_req |-> !bus_turn_ready [*3]) else $error("bus turned early");
  AST_TURN_END: assert property (
    bus_turn_req ##1 !bus_turn_req [*6] |-> bus_turn_ready) else $error("bus turn late");
  AST_STORE: assert property (
    mem_store_en |-> $past(store_req)) else $error("store without request");
  AST_TRAP: assert property (
    cop1_trap |-> $past(fp_instr_valid)) else $error("trap without instruction");
  AST_FILL_START: assert property (
    $rose(fill_word_req) |-> fill_word_index == 2'h0) else $error("fill starts mid block");
  AST_FILL_END: assert property (
    fill_word_req && mem_word_ack && fill_word_index == 2'h3 |=> !fill_word_req
  ) else $error("fill over four words");
  AST_SWAP: assert property (
    $past(cp0_reg_sel) == CMC_SEL_STATUS |-> cp0_rdata[17] == dside_to_icache
  ) else $error("swap output differs from status");
  AST_CACHE: assert property (
    (icache_kb == 5'h10 && dcache_kb == 5'h04) || (icache_kb == 5'h08 && dcache_kb == 5'h08)
  ) else $error("bad cache split");
  cover property (bus_turn_req ##1 !bus_turn_ready [*5]);
  cover property (fill_word_index == 2'h3 && mem_word_ack);
  cover property ($fell(cpu_stall));
endmodule
bind cmc_mode_control cmc_mode_control_assertions #(.INT_W(INT_W)) u_cmc_mode_control_assertions (
  .sys_clk, .reset, .cp0_reg_sel, .cp0_rdata, .cpu_int, .cpu_stall, .bus_turn_req,
  .bus_turn_ready, .store_req, .mem_store_en, .fill_word_req, .fill_word_index,
  .mem_word_ack, .dside_to_icache, .icache_kb, .dcache_kb, .fp_instr_valid, .cop1_trap
);
`default_nettype wire

// ### tb/cmc_mode_control_test.sv
// randomised self-checking bench for the mode control block
`default_nettype none
module cmc_mode_control_test
  import cmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, a); end end
  logic sys_clk = 1'h0;
  logic reset, cp0_wr_en, mode_burst_fill_strap, fpu_exception, bus_turn_req, store_req;
  logic dcache_access, dcache_hit, mem_word_ack, fp_instr_valid, fpu_cmp_valid;
  logic fpu_cmp_result, fpu_cond_wr, fpu_cond_wdata, cpu_stall, cpu_clk_tick, sysclk_tick;
  logic bus_turn_ready, mem_store_en, fill_word_req, dside_to_icache, cop1_trap;
  logic fpu_condition_flag, cond_exp;
  logic [1:0] fill_word_index;
  logic [4:0] cp0_reg_sel, icache_kb, dcache_kb;
  logic [5:0] int_pins_n, cpu_int, hot;
  logic [31:0] cp0_wdata, cp0_rdata, rd_val, m_exp, r;
  int n_fail = 0;
  int total_checks = 0;
  int n;
  cmc_mode_control u_cmc_mode_control (
    .sys_clk, .reset, .cp0_reg_sel, .cp0_wr_en, .cp0_wdata, .cp0_rdata,
    .mode_burst_fill_strap, .int_pins_n, .fpu_exception, .cpu_int, .cpu_stall,
    .cpu_clk_tick, .sysclk_tick, .bus_turn_req, .bus_turn_ready, .store_req,
    .mem_store_en, .dcache_access, .dcache_hit, .fill_word_req, .fill_word_index,
    .mem_word_ack, .dside_to_icache, .icache_kb, .dcache_kb, .fp_instr_valid,
    .cop1_trap, .fpu_cmp_valid, .fpu_cmp_result, .fpu_cond_wr, .fpu_cond_wdata,
    .fpu_condition_flag
  );
  always #5 sys_clk = ~sys_clk;
  // reserved bits always read back as zero
  function automatic logic [31:0] mode_rd(input logic [31:0] w);
    return w & 32'hfff0_0000;
  endfunction
  task automatic wr(input logic [4:0] s, input logic [31:0] d);
    @(posedge sys_clk) {cp0_reg_sel, cp0_wdata, cp0_wr_en} <= {s, d, 1'h1};
    @(posedge sys_clk) cp0_wr_en <= 1'h0;
  endtask
  // rdata lags the select by one edge, so two edges are waited
  task automatic rd(input logic [4:0] s);
    @(posedge sys_clk) cp0_reg_sel <= s;
    repeat (2) @(posedge sys_clk);
    #1 rd_val = cp0_rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bound(input int k);
    if (k >= 20) begin
      n_fail++;
      print_verdict();
    end
  endtask
  initial begin
    {cp0_wr_en, bus_turn_req, store_req, dcache_access, dcache_hit, mem_word_ack} = '0;
    {fp_instr_valid, fpu_exception, fpu_cmp_valid, fpu_cmp_result, fpu_cond_wr} = '0;
    {fpu_cond_wdata, cp0_reg_sel, cp0_wdata} = '0;
    {reset, mode_burst_fill_strap, int_pins_n} = {2'h3, 6'h3f};
    r = $urandom(32'h7c93);
    repeat (15) @(posedge sys_clk);
    @(posedge sys_clk) {reset, fpu_exception} <= 2'h1;
    rd(CMC_SEL_MODE_CONTROL);
    `CHK("reset mode", mode_rd({2'h0, 1'h1, CMC_FPU_IRQ_RESET, 23'h0}), rd_val)
    `CHK("default fpu irq", 6'h08, cpu_int)
    `CHK("icache", CMC_ICACHE_KB_NORMAL, icache_kb)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      m_exp = $urandom & 32'h7fb0_0000;
      wr(CMC_SEL_MODE_CONTROL, m_exp);
      rd(CMC_SEL_MODE_CONTROL);
      `CHK("mode", mode_rd(m_exp), rd_val)
      `CHK("dcache", m_exp[20] ? 5'h08 : CMC_DCACHE_KB_NORMAL, dcache_kb)
    end
    $display("test mode write done");
    for (int k = 0; k < 6; k++) begin
      hot = 6'h01 << k;
      r = $urandom;
      wr(CMC_SEL_MODE_CONTROL, {3'h0, hot, 23'h0});
      @(posedge sys_clk) {fpu_exception, int_pins_n} <= {r[0], 6'h00};
      settle();
      `CHK("irq route", ~hot | (r[0] ? hot : 6'h00), cpu_int)
    end
    @(posedge sys_clk) {fpu_exception, int_pins_n} <= {1'h0, 6'h3f};
    $display("test irq routing done");
    for (int i = 0; i < 2; i++) begin
      m_exp = i ? 32'h2000_0000 : 32'h0003_0000;
      wr(CMC_SEL_STATUS, m_exp);
      @(posedge sys_clk) {store_req, fp_instr_valid} <= 2'h3;
      rd(CMC_SEL_STATUS);
      `CHK("status", m_exp, rd_val)
      `CHK("store", 1'(i), mem_store_en)
      `CHK("swap", 1'(!i), dside_to_icache)
      `CHK("trap", 1'(!i), cop1_trap)
    end
    $display("test status done");
    for (int b = 0; b < 2; b++) begin
      wr(CMC_SEL_MODE_CONTROL, {2'h0, 1'(b), 29'h0});
      @(posedge sys_clk) {dcache_access, dcache_hit} <= 2'h2;
      @(posedge sys_clk) {dcache_access, mem_word_ack} <= 2'h1;
      // sample 1 ns after each edge, never in the edge's own time step
      #1 n = 0;
      while (fill_word_req && n < 20) begin
        @(posedge sys_clk) n++;
        #1;
      end
      bound(n);
      @(posedge sys_clk) mem_word_ack <= 1'h0;
      `CHK("fill words", b ? 3'h4 : 3'h1, 3'(n))
    end
    wr(CMC_SEL_STATUS, 32'h0001_0000);
    for (int h = 1; h >= 0; h--) begin
      @(posedge sys_clk) {dcache_access, dcache_hit} <= {1'h1, 1'(h)};
      @(posedge sys_clk) dcache_access <= 1'h0;
      rd(CMC_SEL_STATUS);
      `CHK("isolated miss", {12'h000, 1'(!h), 19'h1_0000}, rd_val)
      `CHK("isolated fill", 1'h0, fill_word_req)
    end
    wr(CMC_SEL_STATUS, 32'h0000_0000);
    $display("test fill done");
    for (int s = 0; s < 2; s++) begin
      wr(CMC_SEL_MODE_CONTROL, {1'h0, 1'(s), 30'h0});
      @(posedge sys_clk) bus_turn_req <= 1'h1;
      @(posedge sys_clk) bus_turn_req <= 1'h0;
      #1 n = 0;
      while (!bus_turn_ready && n < 20) begin
        @(posedge sys_clk) n++;
        #1;
      end
      bound(n);
      `CHK("turn", s ? CMC_TURN_SLOW_RAW : CMC_TURN_NORMAL_RAW, n)
      wr(CMC_SEL_MODE_CONTROL, {10'h0, 1'(s), 21'h0});
      repeat (20) @(posedge sys_clk);
      n = 0;
      repeat (32) begin
        @(posedge sys_clk);
        #1 n += int'(sysclk_tick);
      end
      `CHK("ticks", s ? 2 : 32, n)
    end
    $display("test turn and clock done");
    wr(CMC_SEL_MODE_CONTROL, 32'h0440_0000);
    settle();
    `CHK("stall", 1'h1, cpu_stall)
    `CHK("cpu tick", 1'h0, cpu_clk_tick)
    @(posedge sys_clk) int_pins_n <= 6'h3e;
    settle();
    `CHK("wake", 1'h0, cpu_stall)
    @(posedge sys_clk) int_pins_n <= 6'h3f;
    cond_exp = 1'h0;
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      @(posedge sys_clk) {fpu_cmp_valid, fpu_cmp_result, fpu_cond_wr, fpu_cond_wdata} <= r[3:0];
      cond_exp = r[3] ? r[2] : (r[1] ? r[0] : cond_exp);
      settle();
      `CHK("condition", cond_exp, fpu_condition_flag)
    end
    $display("test halt and condition done");
    wr(CMC_SEL_MODE_CONTROL, 32'h8010_0000);
    wr(CMC_SEL_MODE_CONTROL, 32'h0000_0000);
    rd(CMC_SEL_MODE_CONTROL);
    `CHK("locked", 32'h8010_0000, rd_val)
    @(posedge sys_clk) {reset, mode_burst_fill_strap} <= 2'h2;
    @(posedge sys_clk) reset <= 1'h0;
    rd(CMC_SEL_MODE_CONTROL);
    `CHK("unlocked", mode_rd({3'h0, CMC_FPU_IRQ_RESET, 23'h0}), rd_val)
    wr(CMC_SEL_MODE_CONTROL, 32'h2000_0000);
    rd(CMC_SEL_MODE_CONTROL);
    `CHK("burst rewrite", 32'h2000_0000, rd_val)
    $display("test lock done");
    print_verdict();
  end
endmodule
`default_nettype wire
